// ---- verilog/ubg_pkg.sv ----
package ubg_pkg;
    // register addresses on the cpu memory map
    localparam logic [15:0] UBG_ADDR_PORT_DIR = 16'hff22;
    localparam logic [15:0] UBG_ADDR_SER_MODE = 16'hffa0;
    localparam logic [15:0] UBG_ADDR_BAUD_DIV = 16'hffa2;
    // reset values
    localparam logic [7:0] UBG_RST_PORT_DIR = 8'hff;
    localparam logic [7:0] UBG_RST_SER_MODE = 8'h00;
    localparam logic [7:0] UBG_RST_BAUD_DIV = 8'h00;
    // serial_mode field positions
    localparam int UBG_TX_EN_BIT = 7;
    localparam int UBG_RX_EN_BIT = 6;
    localparam int UBG_PARITY_HI = 5;
    localparam int UBG_PARITY_LO = 4;
    localparam int UBG_CHAR_LEN_BIT = 3;
    localparam int UBG_STOP_LEN_BIT = 2;
    localparam int UBG_ERR_IRQ_SUP_BIT = 1;
    localparam int UBG_INFRARED_BIT = 0;
    // baud_divider_control field positions
    localparam int UBG_SRC_SEL_HI = 6;
    localparam int UBG_SRC_SEL_LO = 4;
    localparam int UBG_DIVISOR_HI = 3;
    localparam int UBG_DIVISOR_LO = 0;
    // divisor base: counter period is k plus this value
    localparam logic [4:0] UBG_DIV_BASE = 5'h10;
    // source select code meaning the external clock pin
    localparam logic [2:0] UBG_SRC_EXT = 3'h0;
    // port 2 pin positions of the serial pins
    localparam int UBG_RX_PIN = 3;
    localparam int UBG_TX_PIN = 4;
    localparam int UBG_EXT_CLK_PIN = 5;
    // parity select codes
    typedef enum logic [1:0] {
        UBG_PAR_NONE = 2'b00,
        UBG_PAR_ZERO = 2'b01,
        UBG_PAR_ODD = 2'b10,
        UBG_PAR_EVEN = 2'b11
    } ubg_parity_t;
endpackage

// ---- verilog/ubg_edge_sync.sv ----
`timescale 1ns/10ps
// two-flop synchroniser with a rising edge detector behind it
module ubg_edge_sync (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    logic meta_q; // first stage, read only by the second
    logic sync_q; // synchronised level
    logic prev_q; // level one cycle earlier

    // shift chain; edge detection looks only at the later stages
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
endmodule

// ---- verilog/ubg_top.sv ----
`timescale 1ns/10ps
// What this block does
// - 3-bit code picks pin clock or divided clock
// - 4-bit divisor divides source by 16 plus k
// - baud equals fx over 2^(n+1) times (k+16)
// - external pin rate replaces fx in formula
// - reset clears baud divider register
// - direction bit zero drives, one inputs
// - reset sets direction register all ones
// - both enables clear: no transfer, ports
// - reset clears serial mode register
// - full-duplex framing supported via independent enables
// - each enable hands its pin data to serial; the direction bit still sets the drive
// - serial mode bit layout is fixed
// - settings can reach 31.25 kbps
// - parity field gives four parity options
// - length bit picks 7 or 8 bits
module ubg_top #(
    parameter int PORT_W = 6
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    input wire logic [PORT_W-1:0] port_output_latch_i,
    input wire logic [PORT_W-1:0] pin_in_i,
    output logic [PORT_W-1:0] pin_out_o,
    output logic [PORT_W-1:0] pin_oe_o,
    input wire logic serial_out_data_i,
    output logic serial_in_data_o,
    output logic tx_enable_o,
    output logic rx_enable_o,
    output ubg_pkg::ubg_parity_t parity_sel_o,
    output logic char_len8_o,
    output logic stop_len2_o,
    output logic error_irq_suppress_o,
    output logic infrared_mode_o,
    output logic half_tick_o,
    output logic baud_tick_o
);
    import ubg_pkg::*;

    logic [7:0] port_direction_q; // pin direction, one means input
    logic [7:0] serial_mode_q; // enables and frame format
    logic [7:0] baud_divider_control_q; // source select and divisor
    logic [7:0] rdata_q; // registered read data
    logic [6:0] presc_q; // free running main clock prescaler
    logic [4:0] cnt_q; // 5-bit baud counter
    logic phase_q; // selects every second counter wrap
    logic half_q; // half bit tick register
    logic baud_q; // full bit tick register
    logic [PORT_W-1:0] pin_out_q; // registered pin drive value
    logic [PORT_W-1:0] pin_oe_q; // registered pin enables
    logic serial_in_q; // registered serial input
    logic ext_level; // synchronised external clock level
    logic ext_rise; // external clock rising edge

    // address decode
    wire sel_dir = cpu_addr_i == UBG_ADDR_PORT_DIR;
    wire sel_mode = cpu_addr_i == UBG_ADDR_SER_MODE;
    wire sel_baud = cpu_addr_i == UBG_ADDR_BAUD_DIV;
    wire wr_dir = cpu_wr_i & sel_dir;
    wire wr_mode = cpu_wr_i & sel_mode;
    wire wr_baud = cpu_wr_i & sel_baud;
    // read mux; unmapped addresses read zero
    wire [7:0] rd_mux = sel_dir ? port_direction_q :
                        sel_mode ? serial_mode_q :
                        sel_baud ? baud_divider_control_q : 8'h00;

    // mode field decode
    wire tx_en = serial_mode_q[UBG_TX_EN_BIT];
    wire rx_en = serial_mode_q[UBG_RX_EN_BIT];
    wire running = tx_en | rx_en;
    wire [2:0] src_sel = baud_divider_control_q[UBG_SRC_SEL_HI:UBG_SRC_SEL_LO];
    wire [3:0] divisor = baud_divider_control_q[UBG_DIVISOR_HI:UBG_DIVISOR_LO];

    // prescaler tap: divide by two to the n, low n bits all ones
    wire [7:0] pre_mask8 = (8'h01 << src_sel) - 8'h01;
    wire [6:0] pre_mask = pre_mask8[6:0];
    wire int_tick = (presc_q & pre_mask) == pre_mask;
    // source tick from the pin or from the prescaler
    wire src_tick = (src_sel == UBG_SRC_EXT) ? ext_rise : int_tick;
    // last count of the 5-bit counter is k plus 15
    wire [4:0] cnt_last = UBG_DIV_BASE + {1'b0, divisor} - 5'h01;
    wire cnt_wrap = src_tick & (cnt_q == cnt_last);

    // external clock pin into the main clock domain
    ubg_edge_sync u_ext_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(pin_in_i[UBG_EXT_CLK_PIN]),
        .level_o(ext_level),
        .rise_o(ext_rise)
    );

    // pin function select per pin
    wire [PORT_W-1:0] serial_owns;
    wire [PORT_W-1:0] pin_out_d;
    wire [PORT_W-1:0] pin_oe_d;
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            // tx pin takes serial data only while transmit is enabled
            assign serial_owns[gi] = (gi == UBG_TX_PIN) ? tx_en : 1'b0;
            assign pin_out_d[gi] = serial_owns[gi] ? serial_out_data_i :
                                   port_output_latch_i[gi];
            assign pin_oe_d[gi] = ~port_direction_q[gi];
        end
    endgenerate

    // receive pin feeds the receiver only while receive is enabled; idle high
    wire serial_in_d = rx_en ? pin_in_i[UBG_RX_PIN] : 1'b1;

    // register writes and reset values
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            port_direction_q <= UBG_RST_PORT_DIR;
            serial_mode_q <= UBG_RST_SER_MODE;
            baud_divider_control_q <= UBG_RST_BAUD_DIV;
        end else begin
            if (wr_dir) begin
                port_direction_q <= cpu_wdata_i;
            end
            if (wr_mode) begin
                serial_mode_q <= cpu_wdata_i;
            end
            if (wr_baud) begin
                baud_divider_control_q <= cpu_wdata_i;
            end
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
        end else if (cpu_rd_i) begin
            rdata_q <= rd_mux;
        end
    end

    // main clock prescaler, free running
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            presc_q <= 7'h00;
        end else begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // 5-bit counter; held in stop mode and restarted on a divider write
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !running || wr_baud) begin
            cnt_q <= 5'h00;
            phase_q <= 1'b0;
        end else if (cnt_wrap) begin
            cnt_q <= 5'h00;
            phase_q <= ~phase_q;
        end else if (src_tick) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // tick outputs: half every wrap, full every second wrap
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            half_q <= 1'b0;
            baud_q <= 1'b0;
        end else begin
            half_q <= cnt_wrap & running & ~wr_baud;
            baud_q <= cnt_wrap & running & ~wr_baud & phase_q;
        end
    end

    // pin drivers and serial input from flip-flops
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
            serial_in_q <= 1'b1;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            serial_in_q <= serial_in_d;
        end
    end

    assign cpu_rdata_o = rdata_q;
    assign pin_out_o = pin_out_q;
    assign pin_oe_o = pin_oe_q;
    assign serial_in_data_o = serial_in_q;
    assign tx_enable_o = tx_en;
    assign rx_enable_o = rx_en;
    assign parity_sel_o = ubg_parity_t'(serial_mode_q[UBG_PARITY_HI:UBG_PARITY_LO]);
    assign char_len8_o = serial_mode_q[UBG_CHAR_LEN_BIT];
    assign stop_len2_o = serial_mode_q[UBG_STOP_LEN_BIT];
    assign error_irq_suppress_o = serial_mode_q[UBG_ERR_IRQ_SUP_BIT];
    assign infrared_mode_o = serial_mode_q[UBG_INFRARED_BIT];
    assign half_tick_o = half_q;
    assign baud_tick_o = baud_q;

    // reset values seen right after reset
    property p_reset_vals;
        @(posedge ref_clk_i) !resetn_i |=> port_direction_q == UBG_RST_PORT_DIR
            && serial_mode_q == UBG_RST_SER_MODE && baud_divider_control_q == UBG_RST_BAUD_DIV;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    // direction bit drives the pin enable one cycle later
    property p_dir_oe;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            1'b1 |=> pin_oe_o[UBG_TX_PIN] == !$past(port_direction_q[UBG_TX_PIN]);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("pin enable not from direction");

    // stop mode: no ticks at all
    property p_stop_quiet;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            (!running)[*2] |=> !half_tick_o && !baud_tick_o;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("tick in stop mode");

    // tx pin carries latch when transmit disabled, serial data when enabled
    property p_tx_mux;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            1'b1 |=> pin_out_o[UBG_TX_PIN] == ($past(tx_en) ? $past(serial_out_data_i)
                                              : $past(port_output_latch_i[UBG_TX_PIN]));
    endproperty
    a_tx_mux: assert property (p_tx_mux) else $error("tx pin mux wrong");

    // receiver sees the pin only while enabled
    property p_rx_mux;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            !rx_en |=> serial_in_data_o;
    endproperty
    a_rx_mux: assert property (p_rx_mux) else $error("rx input not idle");

    // a full bit tick always coincides with a half tick
    property p_full_half;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            baud_tick_o |-> half_tick_o;
    endproperty
    a_full_half: assert property (p_full_half) else $error("full tick without half");

    // divide by two source: ticks alternate
    property p_div2;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            (src_sel == 3'h1) && src_tick |=> !src_tick || $changed(src_sel);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two source wrong");

    // counter never passes its last value
    property p_cnt_bound;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            $stable(baud_divider_control_q) && running |-> cnt_q <= cnt_last;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("counter overran divisor");

    // pin clock source: no source tick without a synced edge
    property p_ext_src;
        @(posedge ref_clk_i) disable iff (!resetn_i)
            (src_sel == UBG_SRC_EXT) && src_tick |-> ext_level && !$past(ext_level);
    endproperty
    a_ext_src: assert property (p_ext_src) else $error("ext tick without edge");
endmodule

// ---- verif/ubg_line_partner.sv ----
`timescale 1ns/10ps
// far-end transceiver: holds the receive line and supplies the external baud clock
module ubg_line_partner (
    input wire logic ref_clk_i,
    input wire logic clk_run_i,
    input wire logic rx_level_i,
    output logic [5:0] pin_o
);
    logic [1:0] div_q; // half period counter of the pin clock
    logic ext_clk_q; // pin clock, stands low while idle
    // pin clock toggles every 4 main cycles, only while running
    always_ff @(posedge ref_clk_i) begin
        if (!clk_run_i) begin
            div_q <= 2'h0;
            ext_clk_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                ext_clk_q <= ~ext_clk_q;
            end
        end
    end
    // spare pins sit on pull-ups; pin 4 belongs to the device
    assign pin_o = {ext_clk_q, 1'b1, rx_level_i, 3'h7};
endmodule

// ---- verif/ubg_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module ubg_top_tb;
    import ubg_pkg::*;
    logic ref_clk_i = 1'b0; // main clock
    logic resetn_i = 1'b0; // held low at start
    logic [15:0] addr = 16'h0000; // bus address
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic [7:0] wdata = 8'h00; // write data
    logic [7:0] rdata; // read data
    logic [5:0] latch = 6'h3a; // port output latch, tx pin latch starts high
    logic [5:0] pin_in, pin_out, pin_oe, far_pin; // pin wires
    logic sout = 1'b0; // transmitter data
    logic sin, txe, rxe, cl8, sl2, eis, irm, half, baud; // design outputs
    ubg_parity_t par; // parity output
    logic clk_run = 1'b0; // partner pin clock enable
    logic rx_lvl = 1'b1; // partner receive line level
    int miscompares = 0;
    int checked = 0;
    logic [7:0] v; // scratch value
    int n; // measured interval
    logic [7:0] codes [4] = '{8'h10, 8'h31, 8'h7e, 8'h30}; // baud settings
    always #4 ref_clk_i = ~ref_clk_i;
    // wire level: device drives where enabled, else the far side
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & far_pin);
    ubg_top uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cpu_addr_i(addr),
        .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .port_output_latch_i(latch), .pin_in_i(pin_in), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .serial_out_data_i(sout), .serial_in_data_o(sin),
        .tx_enable_o(txe), .rx_enable_o(rxe), .parity_sel_o(par), .char_len8_o(cl8),
        .stop_len2_o(sl2), .error_irq_suppress_o(eis), .infrared_mode_o(irm),
        .half_tick_o(half), .baud_tick_o(baud));
    ubg_line_partner far (.ref_clk_i(ref_clk_i), .clk_run_i(clk_run),
        .rx_level_i(rx_lvl), .pin_o(far_pin));
    // verdict and end of run
    task automatic conclude();
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one-cycle register write
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
    endtask
    // read, data taken at the falling edge after the edge that samples the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(rdata, e)
    endtask
    // cycles between two pulses of the chosen tick, bounded
    task automatic meas(input bit sel, output int cnt);
        int i;
        cnt = 0;
        for (i = 0; i < 40000; i++) begin
            @(negedge ref_clk_i);
            if ((sel ? half : baud) === 1'b1) begin
                if (cnt > 0) break;
                cnt = 1;
            end else if (cnt > 0) cnt++;
        end
        if (i == 40000) begin
            miscompares++;
            $display("CHECK FAILED t=%0t tick timeout", $time);
            conclude();
        end
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd_chk(UBG_ADDR_BAUD_DIV, 8'h00);
        rd_chk(UBG_ADDR_PORT_DIR, 8'hff);
        rd_chk(UBG_ADDR_SER_MODE, 8'h00);
        rd_chk(16'hff21, 8'h00);
        `CHK(pin_oe, 6'h00)
        // stop mode: no ticks, receive copy idle
        n = 0;
        repeat (300) begin
            @(negedge ref_clk_i);
            if (baud === 1'b1 || half === 1'b1) n++;
        end
        `CHK(n, 0)
        `CHK(sin, 1'b1)
        // field layout and parity codes
        for (int i = 0; i < 4; i++) begin
            v = {2'b00, i[1:0], i[0], ~i[0], i[1], ~i[1]};
            wr_reg(UBG_ADDR_SER_MODE, v);
            `CHK(par, ubg_parity_t'(v[5:4]))
            `CHK({cl8, sl2, eis, irm}, v[3:0])
            rd_chk(UBG_ADDR_SER_MODE, v);
        end
        // tx pin drive: direction and latch cleared by software
        wr_reg(UBG_ADDR_PORT_DIR, 8'hef);
        `CHK(pin_oe, 6'h10)
        `CHK(pin_out[4], 1'b1)
        @(posedge ref_clk_i);
        latch <= latch & 6'h2f;
        wr_reg(UBG_ADDR_SER_MODE, 8'h00);
        `CHK(pin_out[4], 1'b0)
        wr_reg(UBG_ADDR_SER_MODE, 8'hc0);
        `CHK({txe, rxe}, 2'b11)
        @(posedge ref_clk_i);
        sout <= 1'b1;
        rx_lvl <= 1'b0;
        repeat (6) @(negedge ref_clk_i);
        `CHK(pin_out[4], 1'b1)
        `CHK(sin, 1'b0)
        wr_reg(UBG_ADDR_SER_MODE, 8'h80);
        repeat (3) @(negedge ref_clk_i);
        `CHK(sin, 1'b1)
        wr_reg(UBG_ADDR_SER_MODE, 8'h00);
        @(posedge ref_clk_i);
        rx_lvl <= 1'b1;
        // divided main clock rates, stopped while the divider changes
        for (int i = 0; i < 4; i++) begin
            v = codes[i];
            wr_reg(UBG_ADDR_BAUD_DIV, v);
            rd_chk(UBG_ADDR_BAUD_DIV, v);
            wr_reg(UBG_ADDR_SER_MODE, 8'h80);
            meas(1'b0, n);
            `CHK(n, (2 << v[6:4]) * (v[3:0] + 16))
            meas(1'b1, n);
            `CHK(n, (1 << v[6:4]) * (v[3:0] + 16))
            wr_reg(UBG_ADDR_SER_MODE, 8'h00);
        end
        // external pin clock as source: 8 cycle pin period
        wr_reg(UBG_ADDR_BAUD_DIV, UBG_RST_BAUD_DIV);
        clk_run <= 1'b1;
        wr_reg(UBG_ADDR_SER_MODE, 8'h40);
        `CHK(pin_out[4], 1'b0)
        meas(1'b0, n);
        `CHK(n, 2 * 16 * 8)
        wr_reg(UBG_ADDR_SER_MODE, 8'h00);
        clk_run <= 1'b0;
        conclude();
    end
endmodule
